// *** rtl/cpsr_pkg.sv ***
// constants and types for the coprocessor context save/restore controller
package cpsr_pkg;
  // interface register offsets on the coprocessor side
  localparam logic [4:0] IFR_RESP = 5'h00;
  localparam logic [4:0] IFR_CTRL = 5'h02;
  localparam logic [4:0] IFR_SAVE = 5'h04;
  localparam logic [4:0] IFR_REST = 5'h06;
  localparam logic [4:0] IFR_OPND = 5'h10;
  // control register: exception acknowledge in bit 1, abort in bit 0
  localparam int CTL_ABORT_BIT = 0;
  localparam int CTL_XACK_BIT = 1;
  localparam logic [31:0] ABORT_MASK = 32'h00000001;
  // format word layout and codes
  localparam int FMT_CODE_LSB = 8;
  localparam int FMT_LEN_LSB = 0;
  localparam logic [7:0] FMT_EMPTY = 8'h00;
  localparam logic [7:0] FMT_NOT_READY = 8'h01;
  localparam logic [7:0] FMT_INVALID = 8'h02;
  // opcode word fields
  localparam int OP_COP_ID_LSB = 9;
  localparam int OP_EA_LSB = 0;
  localparam logic [2:0] EA_PREDEC = 3'h4;
  // software port offsets
  localparam logic [4:0] SW_CTRL = 5'h00;
  localparam logic [4:0] SW_OPWORD = 5'h04;
  localparam logic [4:0] SW_EADDR = 5'h08;
  localparam logic [4:0] SW_STATUS = 5'h0C;
  localparam logic [4:0] SW_FORMAT = 5'h10;
  localparam logic [4:0] SW_RESP = 5'h14;
  // software control bits
  localparam int CTL_GO_SAVE = 0;
  localparam int CTL_GO_REST = 1;
  localparam int CTL_SUPER = 2;
  localparam int CTL_GO_RESP = 3;
  // software status bits
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_PRIV = 2;
  localparam int ST_FMT = 3;
  localparam int ST_FLINE = 4;
  localparam int ST_CNT_LSB = 8;
  localparam int ST_RETRY_LSB = 16;
  // reset values
  localparam logic [15:0] OPWORD_RST = 16'h0000;
  localparam logic [31:0] EADDR_RST = 32'h00000000;
  // interrupt service window after a not-ready answer
  localparam int CLK_PERIOD_NS = 100;
  localparam int SVC_TIME_NS = 400;
  localparam int SVC_CYC = (SVC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // controller states
  typedef enum logic [3:0] {
    CS_IDLE, CS_SV_RD, CS_SV_SVC, CS_SV_FMT, CS_SV_OPRD, CS_SV_OPWR,
    CS_RS_MRD, CS_RS_WR, CS_RS_RD, CS_RS_OPRD, CS_RS_OPWR, CS_ABORT, CS_RESP
  } cpsr_state_type;
endpackage

// *** rtl/cpsr_port.sv ***
// single-access engine: one strobe cycle, read data taken in the following cycle
`timescale 1ns/10ps
`default_nettype none
module cpsr_port #(
  parameter int AW = 32,
  parameter int DW = 32
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic write,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [AW-1:0] p_addr,
  output logic [DW-1:0] p_wdata,
  output logic p_wr,
  output logic p_rd,
  input wire logic [DW-1:0] p_rdata,
  output logic done,
  output logic [DW-1:0] rdata
);
  logic data_phase;

  // strobes last one cycle; address and data hold until the next access
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      p_wr <= 1'b0;
      p_rd <= 1'b0;
      p_addr <= '0;
      p_wdata <= '0;
    end else begin
      p_wr <= start && write;
      p_rd <= start && !write;
      if (start) begin
        p_addr <= addr;
        p_wdata <= wdata;
      end
    end
  end

  // far end answers in the cycle after the strobe; done follows one cycle later
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      data_phase <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
    end else begin
      data_phase <= p_wr || p_rd;
      done <= data_phase;
      if (data_phase) begin
        rdata <= p_rdata;
      end
    end
  end
endmodule // cpsr_port
`default_nettype wire

// *** rtl/cpsr_ctrl.sv ***
// main-processor side sequencer for coprocessor context save and restore
`timescale 1ns/10ps
`default_nettype none
// How it works
// - not-ready on save read: service interrupts, then read save register again
// - coprocessor suspends or finishes its instruction after answering not-ready
// - coprocessor then presents a format code describing its state
// - low byte counts state bytes, excluding format word and null word
// - coprocessor is idle after a finished save
// - coprocessor may answer invalid when busy with save or restore
// - coprocessor stops, checks word, echoes a valid word
// - invalid restore word: abort value 0001 to control, format error
// - coprocessor provides the full interface register set
// - service requests sit in the 16-bit register at offset zero
// - control register: acknowledge bit 1, abort bit 0
// - coprocessor provides a 16-bit save register
// - coprocessor provides a 16-bit restore register
// - state moves as long words through the 32-bit operand register
module cpsr_ctrl (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [4:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic [4:0] ifr_addr,
  output logic [31:0] ifr_wdata,
  output logic ifr_wr,
  output logic ifr_rd,
  input wire logic [31:0] ifr_rdata,
  output logic [2:0] ifr_cop_id,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  input wire logic [31:0] mem_rdata,
  output logic svc_window
);
  import cpsr_pkg::*;

  cpsr_state_type st;
  logic pend;
  logic c_go, c_we, c_done;
  logic [4:0] c_addr;
  logic [31:0] c_wd, c_rd;
  logic m_go, m_we, m_done;
  logic [31:0] m_addr, m_wd, m_rd;
  logic [15:0] opword, fmt, resp;
  logic [31:0] eaddr, data;
  logic [7:0] len, cnt, gap, retries;
  logic sup, busy, done_f, priv_err, fmt_err, fline_err;
  logic ctrl_wr, go_save, go_rest, go_resp;

  // save accepts control alterable plus predecrement
  function automatic logic ea_ok_save(input logic [5:0] ea);
    case (ea[5:3])
      3'h2, 3'h4, 3'h5, 3'h6: ea_ok_save = 1'b1;
      3'h7: ea_ok_save = (ea[2:0] <= 3'h1);
      default: ea_ok_save = 1'b0;
    endcase
  endfunction

  // restore accepts memory modes except predecrement; immediate is refused
  function automatic logic ea_ok_rest(input logic [5:0] ea);
    case (ea[5:3])
      3'h2, 3'h3, 3'h5, 3'h6: ea_ok_rest = 1'b1;
      3'h7: ea_ok_rest = (ea[2:0] <= 3'h3);
      default: ea_ok_rest = 1'b0;
    endcase
  endfunction

  // command decode: go bits are ignored while a sequence runs
  assign ctrl_wr = sw_wr && (sw_addr == SW_CTRL) && (st == CS_IDLE);
  assign go_save = ctrl_wr && sw_wdata[CTL_GO_SAVE];
  assign go_rest = ctrl_wr && sw_wdata[CTL_GO_REST] && !sw_wdata[CTL_GO_SAVE];
  assign go_resp = ctrl_wr && sw_wdata[CTL_GO_RESP] && !sw_wdata[CTL_GO_SAVE] && !sw_wdata[CTL_GO_REST];

  cpsr_port #(.AW(5), .DW(32)) ifr_port_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(c_go),
    .write(c_we),
    .addr(c_addr),
    .wdata(c_wd),
    .p_addr(ifr_addr),
    .p_wdata(ifr_wdata),
    .p_wr(ifr_wr),
    .p_rd(ifr_rd),
    .p_rdata(ifr_rdata),
    .done(c_done),
    .rdata(c_rd)
  );

  cpsr_port #(.AW(32), .DW(32)) mem_port_inst (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .start(m_go),
    .write(m_we),
    .addr(m_addr),
    .wdata(m_wd),
    .p_addr(mem_addr),
    .p_wdata(mem_wdata),
    .p_wr(mem_wr),
    .p_rd(mem_rd),
    .p_rdata(mem_rdata),
    .done(m_done),
    .rdata(m_rd)
  );

  // software-written setup; held steady while a sequence runs
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      opword <= OPWORD_RST;
      eaddr <= EADDR_RST;
      sup <= 1'b0;
    end else if (st == CS_IDLE && sw_wr) begin
      if (sw_addr == SW_OPWORD) begin
        opword <= sw_wdata[15:0];
      end
      if (sw_addr == SW_EADDR) begin
        eaddr <= sw_wdata;
      end
      if (sw_addr == SW_CTRL) begin
        sup <= sw_wdata[CTL_SUPER];
      end
    end
  end

  // read data stands only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sw_rdata <= 32'h00000000;
    end else if (sw_rd) begin
      case (sw_addr)
        SW_CTRL: sw_rdata <= {29'h0, sup, 2'h0};
        SW_OPWORD: sw_rdata <= {16'h0000, opword};
        SW_EADDR: sw_rdata <= eaddr;
        SW_STATUS: sw_rdata <= {8'h00, retries, cnt, 3'h0, fline_err, fmt_err, priv_err, done_f, busy};
        SW_FORMAT: sw_rdata <= {16'h0000, fmt};
        SW_RESP: sw_rdata <= {16'h0000, resp};
        default: sw_rdata <= 32'h00000000;
      endcase
    end else begin
      sw_rdata <= 32'h00000000;
    end
  end

  // sequencer: each access state issues one go, then waits for its done
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= CS_IDLE;
      pend <= 1'b0;
      c_go <= 1'b0;
      c_we <= 1'b0;
      c_addr <= 5'h00;
      c_wd <= 32'h00000000;
      m_go <= 1'b0;
      m_we <= 1'b0;
      m_addr <= 32'h00000000;
      m_wd <= 32'h00000000;
      fmt <= 16'h0000;
      resp <= 16'h0000;
      len <= 8'h00;
      cnt <= 8'h00;
      gap <= 8'h00;
      retries <= 8'h00;
      data <= 32'h00000000;
      busy <= 1'b0;
      done_f <= 1'b0;
      priv_err <= 1'b0;
      fmt_err <= 1'b0;
      fline_err <= 1'b0;
      svc_window <= 1'b0;
      ifr_cop_id <= 3'h0;
    end else begin
      c_go <= 1'b0;
      m_go <= 1'b0;
      case (st)
        CS_IDLE: begin
          if (go_save || go_rest || go_resp) begin
            done_f <= 1'b0;
            priv_err <= 1'b0;
            fmt_err <= 1'b0;
            fline_err <= 1'b0;
            cnt <= 8'h00;
            retries <= 8'h00;
            pend <= 1'b0;
            ifr_cop_id <= opword[OP_COP_ID_LSB +: 3];
            if (go_resp) begin
              busy <= 1'b1;
              st <= CS_RESP;
            end else if (!sw_wdata[CTL_SUPER]) begin
              priv_err <= 1'b1;
              done_f <= 1'b1;
            end else if (go_save ? !ea_ok_save(opword[OP_EA_LSB +: 6]) : !ea_ok_rest(opword[OP_EA_LSB +: 6])) begin
              fline_err <= 1'b1;
              done_f <= 1'b1;
            end else begin
              busy <= 1'b1;
              st <= go_save ? CS_SV_RD : CS_RS_MRD;
            end
          end
        end
        CS_RESP: begin
          if (!pend) begin
            c_go <= 1'b1;
            c_we <= 1'b0;
            c_addr <= IFR_RESP;
            pend <= 1'b1;
          end else if (c_done) begin
            resp <= c_rd[15:0];
            pend <= 1'b0;
            busy <= 1'b0;
            done_f <= 1'b1;
            st <= CS_IDLE;
          end
        end
        CS_SV_RD: begin
          if (!pend) begin
            c_go <= 1'b1;
            c_we <= 1'b0;
            c_addr <= IFR_SAVE;
            pend <= 1'b1;
          end else if (c_done) begin
            pend <= 1'b0;
            fmt <= c_rd[15:0];
            len <= c_rd[FMT_LEN_LSB +: 8];
            if (c_rd[FMT_CODE_LSB +: 8] == FMT_NOT_READY) begin
              // interrupts get a window before the save register is polled again
              retries <= 8'(retries + 8'h01);
              gap <= 8'(SVC_CYC);
              svc_window <= 1'b1;
              st <= CS_SV_SVC;
            end else if (c_rd[FMT_CODE_LSB +: 8] == FMT_INVALID || c_rd[1:0] != 2'b00) begin
              st <= CS_ABORT;
            end else begin
              st <= CS_SV_FMT;
            end
          end
        end
        CS_SV_SVC: begin
          gap <= 8'(gap - 8'h01);
          if (gap <= 8'h01) begin
            svc_window <= 1'b0;
            st <= CS_SV_RD;
          end
        end
        CS_SV_FMT: begin
          if (!pend) begin
            // format word and its null word form one long word
            m_go <= 1'b1;
            m_we <= 1'b1;
            m_addr <= eaddr;
            m_wd <= {fmt, 16'h0000};
            pend <= 1'b1;
          end else if (m_done) begin
            pend <= 1'b0;
            if (fmt[FMT_CODE_LSB +: 8] == FMT_EMPTY || len == 8'h00) begin
              busy <= 1'b0;
              done_f <= 1'b1;
              st <= CS_IDLE;
            end else begin
              st <= CS_SV_OPRD;
            end
          end
        end
        CS_SV_OPRD: begin
          if (!pend) begin
            c_go <= 1'b1;
            c_we <= 1'b0;
            c_addr <= IFR_OPND;
            pend <= 1'b1;
          end else if (c_done) begin
            pend <= 1'b0;
            data <= c_rd;
            st <= CS_SV_OPWR;
          end
        end
        CS_SV_OPWR: begin
          if (!pend) begin
            m_go <= 1'b1;
            m_we <= 1'b1;
            m_addr <= eaddr + 32'h00000004 + {24'h000000, cnt};
            m_wd <= data;
            pend <= 1'b1;
          end else if (m_done) begin
            pend <= 1'b0;
            cnt <= 8'(cnt + 8'h04);
            if (8'(cnt + 8'h04) == len) begin
              busy <= 1'b0;
              done_f <= 1'b1;
              st <= CS_IDLE;
            end else begin
              st <= CS_SV_OPRD;
            end
          end
        end
        CS_RS_MRD: begin
          if (!pend) begin
            m_go <= 1'b1;
            m_we <= 1'b0;
            m_addr <= eaddr;
            pend <= 1'b1;
          end else if (m_done) begin
            pend <= 1'b0;
            fmt <= m_rd[31:16];
            len <= m_rd[16 + FMT_LEN_LSB +: 8];
            st <= (m_rd[17:16] != 2'b00) ? CS_ABORT : CS_RS_WR;
          end
        end
        CS_RS_WR: begin
          if (!pend) begin
            c_go <= 1'b1;
            c_we <= 1'b1;
            c_addr <= IFR_REST;
            c_wd <= {16'h0000, fmt};
            pend <= 1'b1;
          end else if (c_done) begin
            pend <= 1'b0;
            st <= CS_RS_RD;
          end
        end
        CS_RS_RD: begin
          if (!pend) begin
            c_go <= 1'b1;
            c_we <= 1'b0;
            c_addr <= IFR_REST;
            pend <= 1'b1;
          end else if (c_done) begin
            pend <= 1'b0;
            // not-ready on restore is polled again without an interrupt window
            if (c_rd[FMT_CODE_LSB +: 8] == FMT_NOT_READY) begin
              retries <= 8'(retries + 8'h01);
            end else if (c_rd[15:0] != fmt) begin
              st <= CS_ABORT;
            end else if (fmt[FMT_CODE_LSB +: 8] == FMT_EMPTY || len == 8'h00) begin
              busy <= 1'b0;
              done_f <= 1'b1;
              st <= CS_IDLE;
            end else begin
              st <= CS_RS_OPRD;
            end
          end
        end
        CS_RS_OPRD: begin
          if (!pend) begin
            m_go <= 1'b1;
            m_we <= 1'b0;
            m_addr <= eaddr + 32'h00000004 + {24'h000000, cnt};
            pend <= 1'b1;
          end else if (m_done) begin
            pend <= 1'b0;
            data <= m_rd;
            st <= CS_RS_OPWR;
          end
        end
        CS_RS_OPWR: begin
          if (!pend) begin
            c_go <= 1'b1;
            c_we <= 1'b1;
            c_addr <= IFR_OPND;
            c_wd <= data;
            pend <= 1'b1;
          end else if (c_done) begin
            pend <= 1'b0;
            cnt <= 8'(cnt + 8'h04);
            if (8'(cnt + 8'h04) == len) begin
              busy <= 1'b0;
              done_f <= 1'b1;
              st <= CS_IDLE;
            end else begin
              st <= CS_RS_OPRD;
            end
          end
        end
        CS_ABORT: begin
          if (!pend) begin
            c_go <= 1'b1;
            c_we <= 1'b1;
            c_addr <= IFR_CTRL;
            c_wd <= ABORT_MASK;
            pend <= 1'b1;
          end else if (c_done) begin
            pend <= 1'b0;
            fmt_err <= 1'b1;
            busy <= 1'b0;
            done_f <= 1'b1;
            st <= CS_IDLE;
          end
        end
        default: begin
          st <= CS_IDLE;
          pend <= 1'b0;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  localparam int A_NR_LO = SVC_CYC + 2;
  localparam int A_NR_HI = SVC_CYC + 3;
  logic sv_nr, rs_empty;
  assign sv_nr = st == CS_SV_RD && pend && c_done && c_rd[15:8] == FMT_NOT_READY;
  assign rs_empty = st == CS_RS_RD && pend && c_done && c_rd[15:0] == fmt && fmt[15:8] == FMT_EMPTY;
  sequence abort_wr;
    ifr_wr && ifr_addr == IFR_CTRL;
  endsequence
  sequence rest_wr;
    ifr_wr && ifr_addr == IFR_REST;
  endsequence
  sequence rest_rd;
    ifr_rd && ifr_addr == IFR_REST;
  endsequence

  a_priv_no_access: assert property ((go_save || go_rest) && !sw_wdata[CTL_SUPER] |=>
    (priv_err && !ifr_rd && !ifr_wr) [*3]) else $error("privilege check touched the coprocessor");
  a_abort_mask_val: assert property (abort_wr |-> ifr_wdata == ABORT_MASK)
    else $error("abort write carried the wrong value");
  a_abort_then_err: assert property (abort_wr |-> ##3 (fmt_err && done_f && !busy))
    else $error("format error not raised after abort");
  a_notready_retry: assert property (sv_nr |=> svc_window ##[A_NR_LO:A_NR_HI]
    (ifr_rd && ifr_addr == IFR_SAVE)) else $error("save register not polled again");
  a_restore_readback: assert property (rest_wr |-> ##5 rest_rd)
    else $error("restore register not read back");
  a_len_multiple: assert property ((st == CS_SV_OPRD || st == CS_RS_OPRD) |-> len[1:0] == 2'b00)
    else $error("transfer started with bad length");
  a_count_step: assert property ($changed(cnt) |-> (cnt == 8'($past(cnt) + 8'h04) || cnt == 8'h00))
    else $error("byte count moved by other than four");
  a_count_bound: assert property ((st == CS_SV_OPRD || st == CS_RS_OPRD) |-> cnt < len)
    else $error("transfer ran past the stored length");
  a_fline_predec: assert property (go_rest && sw_wdata[CTL_SUPER] && opword[5:3] == EA_PREDEC |=>
    (fline_err && st == CS_IDLE)) else $error("predecrement restore not refused");
  a_empty_skip: assert property (rs_empty |=> (st == CS_IDLE && done_f) ##1 !ifr_wr [*3])
    else $error("empty restore moved operand data");
endmodule // cpsr_ctrl
`default_nettype wire

// *** dv/cpsr_cop.sv ***
// coprocessor and memory model on the far side of the context save/restore controller
`timescale 1ns/10ps
`default_nettype none
module cpsr_cop (
  input wire logic sys_clk,
  input wire logic [4:0] ifr_addr,
  input wire logic [31:0] ifr_wdata,
  input wire logic ifr_wr,
  input wire logic ifr_rd,
  output logic [31:0] ifr_rdata,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  output logic [31:0] mem_rdata
);
  import cpsr_pkg::*;
  // set by the bench between commands: not-ready count, save answer, refuse restore
  logic [3:0] nr_left = 4'h0;
  logic [15:0] save_word = 16'h0000;
  logic bad_rest = 1'b0;
  logic [15:0] rest_word = 16'h0000;
  logic [31:0] last_ctl = 32'h0;
  logic [31:0] last_opw = 32'h0;
  logic [7:0] pat = 8'h00;
  logic [31:0] mem [0:63];
  // cnt: 0 all interface strobes, 1 operand reads, 2 operand writes, 3 control writes
  int cnt [4] = '{0, 0, 0, 0};
  // answers stand only in the cycle after the strobe; otherwise a moving pattern, so stale data never matches
  always @(posedge sys_clk) begin
    pat <= pat + 8'h01;
    ifr_rdata <= {pat, ~pat, pat, ~pat};
    if (ifr_wr || ifr_rd) cnt[0] <= cnt[0] + 1;
    if (ifr_wr && ifr_addr == IFR_CTRL) begin
      last_ctl <= ifr_wdata;
      cnt[3] <= cnt[3] + 1;
    end
    if (ifr_wr && ifr_addr == IFR_REST) rest_word <= ifr_wdata[15:0];
    if (ifr_wr && ifr_addr == IFR_OPND) begin
      last_opw <= ifr_wdata;
      cnt[2] <= cnt[2] + 1;
    end
    // only response, control, save, restore and operand registers decoded; command and condition writes are accepted and dropped
    if (ifr_rd) begin
      case (ifr_addr)
        IFR_RESP: ifr_rdata <= 32'h00004321;
        IFR_SAVE, IFR_REST: begin
          if (nr_left != 4'h0) begin
            nr_left <= nr_left - 4'h1;
            ifr_rdata <= {16'h0000, FMT_NOT_READY, 8'h00};
          end else if (ifr_addr == IFR_SAVE) begin
            ifr_rdata <= {16'h0000, save_word};
          end else begin
            ifr_rdata <= {16'h0000, bad_rest ? {FMT_INVALID, 8'h00} : rest_word};
          end
        end
        IFR_OPND: begin
          ifr_rdata <= 32'hC0DE0000 + cnt[1];
          cnt[1] <= cnt[1] + 1;
        end
        default: ;
      endcase
    end
  end
  // memory with no wait state
  always @(posedge sys_clk) begin
    mem_rdata <= {~pat, pat, ~pat, pat};
    if (mem_wr) mem[mem_addr[7:2]] <= mem_wdata;
    if (mem_rd) mem_rdata <= mem[mem_addr[7:2]];
  end
endmodule // cpsr_cop
`default_nettype wire

// *** dv/tb_cpsr_ctrl.sv ***
// self-checking bench for the context save/restore controller
`timescale 1ns/10ps
`default_nettype none
module tb_cpsr_ctrl;
  import cpsr_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] sw_addr = 5'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata, ifr_wdata, ifr_rdata, mem_addr, mem_wdata, mem_rdata, st;
  logic [4:0] ifr_addr;
  logic [2:0] ifr_cop_id;
  logic ifr_wr, ifr_rd, mem_wr, mem_rd, svc_window;
  int fails = 0;
  int n_tests = 0;
  int svc_n = 0;
  int sv0 = 0;
  int b [4];
  always #50 sys_clk = ~sys_clk;
  // count cycles of the interrupt service pause
  always @(posedge sys_clk) if (svc_window === 1'b1) svc_n++;
  cpsr_ctrl cpsr_ctrl_inst (.sys_clk(sys_clk), .nrst(nrst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .ifr_addr(ifr_addr), .ifr_wdata(ifr_wdata),
    .ifr_wr(ifr_wr), .ifr_rd(ifr_rd), .ifr_rdata(ifr_rdata), .ifr_cop_id(ifr_cop_id), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .svc_window(svc_window));
  cpsr_cop cpsr_cop_inst (.sys_clk(sys_clk), .ifr_addr(ifr_addr), .ifr_wdata(ifr_wdata), .ifr_wr(ifr_wr),
    .ifr_rd(ifr_rd), .ifr_rdata(ifr_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_rdata(mem_rdata));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so take them there
  task automatic rd(input logic [4:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // start a command and poll until idle; a hang counts as a mismatch
  task automatic run(input logic [31:0] cmd);
    int k;
    k = 0;
    wr(SW_CTRL, cmd);
    rd(SW_STATUS, st);
    while (st[ST_BUSY] !== 1'b0 && k < 200) begin
      rd(SW_STATUS, st);
      k++;
    end
    chk("busy cleared", 32'h0, st[ST_BUSY]);
  endtask
  task automatic arm(input logic [3:0] n, input logic [15:0] w, input logic bad);
    #2;
    cpsr_cop_inst.nr_left = n;
    cpsr_cop_inst.save_word = w;
    cpsr_cop_inst.bad_rest = bad;
    b = cpsr_cop_inst.cnt;
    sv0 = svc_n;
  endtask
  function automatic logic [31:0] dl(input int k);
    return cpsr_cop_inst.cnt[k] - b[k];
  endfunction
  task automatic t_reset;
    logic [31:0] d;
    logic [4:0] adr [4];
    adr = '{SW_STATUS, SW_OPWORD, SW_EADDR, 5'h18};
    foreach (adr[i]) begin
      rd(adr[i], d);
      chk("reset or unmapped", 32'h0, d);
    end
    $display("test reset over");
  endtask
  task automatic t_save;
    logic [31:0] d;
    wr(SW_OPWORD, 32'h00000610);
    wr(SW_EADDR, 32'h00000040);
    arm(4'h2, 16'h3008, 1'b0);
    run(32'h5);
    chk("save done", 32'h1, st[ST_DONE]);
    chk("retries", 32'h2, st[ST_RETRY_LSB+:8]);
    chk("service cycles", 2 * SVC_CYC, svc_n - sv0);
    chk("stored format", 32'h30080000, cpsr_cop_inst.mem[16]);
    chk("state word 0", 32'hC0DE0000 + b[1], cpsr_cop_inst.mem[17]);
    chk("state word 1", 32'hC0DE0001 + b[1], cpsr_cop_inst.mem[18]);
    chk("past frame", 32'h5A5A5A5A, cpsr_cop_inst.mem[19]);
    chk("operand reads", 32'h2, dl(1));
    chk("bytes moved", 32'h8, st[ST_CNT_LSB+:8]);
    chk("coprocessor id", 32'h3, ifr_cop_id);
    rd(SW_FORMAT, d);
    chk("format kept", 32'h3008, d[15:0]);
    arm(4'h0, 16'h0000, 1'b0);
    run(32'h5);
    chk("empty save reads", 32'h0, dl(1));
    chk("empty format", 32'h0, cpsr_cop_inst.mem[16]);
    $display("test save over");
  endtask
  task automatic t_save_err;
    logic [15:0] w [2];
    w = '{16'h3006, 16'h0200};
    foreach (w[i]) begin
      arm(4'h0, w[i], 1'b0);
      run(32'h5);
      chk("save format error", 32'h1, st[ST_FMT]);
      chk("abort writes", 32'h1, dl(3));
      chk("abort mask", ABORT_MASK, cpsr_cop_inst.last_ctl);
      chk("no state read", 32'h0, dl(1));
    end
    $display("test save errors over");
  endtask
  task automatic t_priv;
    logic [31:0] c [2];
    c = '{32'h1, 32'h2};
    foreach (c[i]) begin
      arm(4'h0, 16'h0000, 1'b0);
      run(c[i]);
      chk("privilege error", 32'h1, st[ST_PRIV]);
      chk("no register access", 32'h0, dl(0));
    end
    $display("test privilege over");
  endtask
  task automatic t_restore;
    wr(SW_EADDR, 32'h00000080);
    arm(4'h1, 16'h0000, 1'b0);
    cpsr_cop_inst.mem[32] = 32'h3C080000;
    cpsr_cop_inst.mem[33] = 32'h11112222;
    cpsr_cop_inst.mem[34] = 32'h33334444;
    run(32'h6);
    chk("restore done", 32'h1, st[ST_DONE]);
    chk("restore word", 32'h3C08, cpsr_cop_inst.rest_word);
    chk("operand writes", 32'h2, dl(2));
    chk("last operand", 32'h33334444, cpsr_cop_inst.last_opw);
    chk("bytes restored", 32'h8, st[ST_CNT_LSB+:8]);
    arm(4'h0, 16'h0000, 1'b0);
    cpsr_cop_inst.mem[32] = 32'h0;
    run(32'h6);
    chk("empty restore", 32'h0, dl(2));
    chk("empty done", 32'h1, st[ST_DONE]);
    // a stored length that is not a whole number of long words aborts before the restore write
    arm(4'h0, 16'h0000, 1'b0);
    cpsr_cop_inst.mem[32] = 32'h3C060000;
    run(32'h6);
    chk("restore length error", 32'h1, st[ST_FMT]);
    chk("length abort only", 32'h1, dl(0));
    arm(4'h0, 16'h0000, 1'b1);
    cpsr_cop_inst.mem[32] = 32'h3C080000;
    run(32'h6);
    chk("restore format error", 32'h1, st[ST_FMT]);
    chk("restore abort", 32'h1, dl(3));
    chk("restore abort value", 32'h1, cpsr_cop_inst.last_ctl);
    chk("no operand write", 32'h0, dl(2));
    $display("test restore over");
  endtask
  task automatic t_bad_ea;
    logic [31:0] op [2];
    logic [31:0] c [2];
    op = '{32'h0620, 32'h0608};
    c = '{32'h6, 32'h5};
    foreach (op[i]) begin
      wr(SW_OPWORD, op[i]);
      arm(4'h0, 16'h0000, 1'b0);
      run(c[i]);
      chk("emulator error", 32'h1, st[ST_FLINE]);
      chk("no access on bad mode", 32'h0, dl(0));
    end
    $display("test address modes over");
  endtask
  task automatic t_resp;
    logic [31:0] d;
    run(32'hC);
    rd(SW_RESP, d);
    chk("response word", 32'h4321, d[15:0]);
    $display("test response over");
  endtask
  task automatic final_report;
    $display("comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    for (int i = 0; i < 64; i++) cpsr_cop_inst.mem[i] = 32'h5A5A5A5A;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    t_reset;
    t_save;
    t_save_err;
    t_priv;
    t_restore;
    t_bad_ea;
    t_resp;
    final_report;
  end
  // watchdog: the tests need well under 4000 cycles
  initial begin
    #(4000 * 100);
    fails++;
    final_report;
  end
endmodule // tb_cpsr_ctrl
`default_nettype wire
